//--- common/dpc_regs.svh
`ifndef DPC_REGS_SVH
`define DPC_REGS_SVH

// parameter addresses of the capture unit, as the fieldbus sees them
`define DPC_OFS_STATUS     16'h0A02
`define DPC_OFS_EDGE1      16'h0A04
`define DPC_OFS_EDGE2      16'h0A06
`define DPC_OFS_START1     16'h0A08
`define DPC_OFS_START2     16'h0A0A
`define DPC_OFS_POS1       16'h0A0C
`define DPC_OFS_POS2       16'h0A0E
`define DPC_OFS_COUNT1     16'h0A10
`define DPC_OFS_COUNT2     16'h0A12

// start/stop command codes
`define DPC_CMD_STOP       16'h0000
`define DPC_CMD_ONCE       16'h0001
`define DPC_CMD_CONT       16'h0002

// edge select field and reset values
`define DPC_EDGE_BIT       0
`define DPC_EDGE_RST       16'h0000
`define DPC_START_RST      16'h0000

// status word bit of each channel
`define DPC_STAT_CH1_BIT   0
`define DPC_STAT_CH2_BIT   1

// pin synchroniser depth
`define DPC_SYNC_STAGES    3

`endif

//--- common/dpc_pkg.sv
package dpc_pkg;

   // run state of one channel, gray along idle -> once -> continuous
   typedef enum logic [1:0] {
      DPC_IDLE = 2'b00,
      DPC_ONCE = 2'b01,
      DPC_CONT = 2'b11
   } dpc_run_t;

   // parameter access request from the fieldbus side
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [15:0] addr;
      logic [31:0] wdata;
   } dpc_par_req_t;

   // parameter access answer
   typedef struct packed {
      logic        ack;
      logic [31:0] rdata;
   } dpc_par_rsp_t;

   // state of one capture channel
   typedef struct packed {
      logic [2:0]  sync;
      logic        level;
      logic [15:0] edge_sel;
      logic [15:0] start_stop;
      dpc_run_t    run;
      logic        flag;
      logic [31:0] pos;
      logic [15:0] count;
   } dpc_chan_t;

   // whole state of the unit
   typedef struct packed {
      dpc_chan_t [1:0] ch;
      dpc_par_rsp_t    rsp;
   } dpc_state_t;

endpackage

//--- src/dpc_capture.sv
`include "dpc_regs.svh"

module dpc_capture (
   // clock and reset
   input  wire logic                 ref_clk,
   input  wire logic                 reset,
   // capture pins, asynchronous to ref_clk
   input  wire logic                 local_input_one,
   input  wire logic                 local_input_two,
   // motor position in user units and reference redefinition
   input  wire logic signed [31:0]   motor_pos,
   input  wire logic                 pos_redefine,
   input  wire logic signed [31:0]   pos_redefine_delta,
   // parameter access port
   input  wire dpc_pkg::dpc_par_req_t par_req,
   output      dpc_pkg::dpc_par_rsp_t par_rsp
);

   dpc_pkg::dpc_state_t st_r;     // every flip-flop of the unit
   dpc_pkg::dpc_state_t st_nxt;   // its next value
   logic [1:0]          pins;     // raw pins, index = channel
   logic [1:0]          cap;      // qualifying edge seen while armed
   logic [1:0]          start;    // start/stop write with code 1 or 2
   logic [1:0]          wr_ss;    // any start/stop write

   assign pins = {local_input_two, local_input_one};

   // address of a channel register: second channel sits 2 above first
   function automatic logic [15:0] ch_ofs(input logic [15:0] base,
                                          input int unsigned  idx);
      ch_ofs = base + (idx[0] ? 16'h0002 : 16'h0000);
   endfunction

   // decode a start/stop code into a run state
   function automatic dpc_pkg::dpc_run_t decode_cmd(
         input logic [15:0] cmd);
      case (cmd)
         `DPC_CMD_ONCE: decode_cmd = dpc_pkg::DPC_ONCE;
         `DPC_CMD_CONT: decode_cmd = dpc_pkg::DPC_CONT;
         // codes above 2 are treated as a cancel, the safe choice
         default:       decode_cmd = dpc_pkg::DPC_IDLE;
      endcase
   endfunction

   // next-state logic: sync, edge detect, capture, register access
   always_comb begin
      logic rise;
      logic fall;
      logic hit;
      rise   = 1'b0;
      fall   = 1'b0;
      hit    = 1'b0;
      st_nxt = st_r;
      cap    = 2'b00;
      start  = 2'b00;
      wr_ss  = 2'b00;
      st_nxt.rsp.ack = 1'b0;
      for (int i = 0; i < 2; i++) begin
         // three-stage synchroniser; stage 0 feeds only stage 1
         st_nxt.ch[i].sync = {st_r.ch[i].sync[1:0], pins[i]};
         // filtered level moves once stages 1 and 2 agree
         if (st_r.ch[i].sync[1] == st_r.ch[i].sync[2]
             && st_r.ch[i].sync[2] != st_r.ch[i].level) begin
            st_nxt.ch[i].level = st_r.ch[i].sync[2];
            rise = st_r.ch[i].sync[2];
            fall = !st_r.ch[i].sync[2];
         end else begin
            rise = 1'b0;
            fall = 1'b0;
         end
         // polarity chosen by the live setting
         hit = st_r.ch[i].edge_sel[`DPC_EDGE_BIT] ? rise : fall;
         cap[i] = hit && (st_r.ch[i].run != dpc_pkg::DPC_IDLE);
         // setting writes, acting from the next cycle on
         if (par_req.wr && par_req.addr == ch_ofs(`DPC_OFS_EDGE1, i)) begin
            st_nxt.ch[i].edge_sel = par_req.wdata[15:0];
         end
         wr_ss[i] = par_req.wr
                    && par_req.addr == ch_ofs(`DPC_OFS_START1, i);
         start[i] = wr_ss[i] && decode_cmd(par_req.wdata[15:0])
                    != dpc_pkg::DPC_IDLE;
         // run state: a write overrides, else one-time disarms on capture
         if (wr_ss[i]) begin
            st_nxt.ch[i].start_stop = par_req.wdata[15:0];
            st_nxt.ch[i].run = decode_cmd(par_req.wdata[15:0]);
         end else if (cap[i] && st_r.ch[i].run == dpc_pkg::DPC_ONCE) begin
            st_nxt.ch[i].run = dpc_pkg::DPC_IDLE;
         end
         // continuous stays armed: nothing changes run here
         // start clears counter and flag first
         if (start[i]) begin
            st_nxt.ch[i].count = 16'h0000;
            st_nxt.ch[i].flag  = 1'b0;
         end
         // reference moved: shift the held position with it
         if (pos_redefine) begin
            st_nxt.ch[i].pos = st_r.ch[i].pos + pos_redefine_delta;
         end
         // a capture lands on top, so an edge in a start cycle survives
         if (cap[i]) begin
            st_nxt.ch[i].pos   = motor_pos;
            st_nxt.ch[i].flag  = 1'b1;
            // plain 16-bit add wraps to zero
            st_nxt.ch[i].count = (start[i] ? 16'h0000 : st_r.ch[i].count)
                                 + 16'h0001;
         end
      end
      // read answers one cycle later from the state before any write
      if (par_req.rd) begin
         st_nxt.rsp.ack = 1'b1;
         case (par_req.addr)
            `DPC_OFS_STATUS: begin
               st_nxt.rsp.rdata = 32'h0000_0000;
               st_nxt.rsp.rdata[`DPC_STAT_CH1_BIT] = st_r.ch[0].flag;
               st_nxt.rsp.rdata[`DPC_STAT_CH2_BIT] = st_r.ch[1].flag;
            end
            `DPC_OFS_EDGE1:  st_nxt.rsp.rdata = {16'h0000, st_r.ch[0].edge_sel};
            `DPC_OFS_EDGE2:  st_nxt.rsp.rdata = {16'h0000, st_r.ch[1].edge_sel};
            `DPC_OFS_START1: st_nxt.rsp.rdata = {16'h0000, st_r.ch[0].start_stop};
            `DPC_OFS_START2: st_nxt.rsp.rdata = {16'h0000, st_r.ch[1].start_stop};
            `DPC_OFS_POS1:   st_nxt.rsp.rdata = st_r.ch[0].pos;
            `DPC_OFS_POS2:   st_nxt.rsp.rdata = st_r.ch[1].pos;
            `DPC_OFS_COUNT1: st_nxt.rsp.rdata = {16'h0000, st_r.ch[0].count};
            `DPC_OFS_COUNT2: st_nxt.rsp.rdata = {16'h0000, st_r.ch[1].count};
            // unmapped addresses read as zero
            default:         st_nxt.rsp.rdata = 32'h0000_0000;
         endcase
      end
   end

   // state register, synchronous reset
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         st_r <= '0;
         for (int i = 0; i < 2; i++) begin
            st_r.ch[i].edge_sel   <= `DPC_EDGE_RST;
            st_r.ch[i].start_stop <= `DPC_START_RST;
            st_r.ch[i].run        <= dpc_pkg::DPC_IDLE;
         end
      end else begin
         st_r <= st_nxt;
      end
   end

   assign par_rsp = st_r.rsp;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);

   a_edge_polarity: assert property (cap[0] |->
      st_r.ch[0].level != st_r.ch[0].sync[2]
      && st_r.ch[0].sync[2] == st_r.ch[0].edge_sel[0])
      else $error("channel one captured on the wrong edge");
   a_stop_cancels: assert property (
      wr_ss[1] && par_req.wdata[15:0] == 16'h0000
      |=> st_r.ch[1].run == dpc_pkg::DPC_IDLE && !cap[1])
      else $error("cancel did not disarm channel two");
   a_once_disarms: assert property (
      cap[0] && st_r.ch[0].run == dpc_pkg::DPC_ONCE && !wr_ss[0]
      |=> st_r.ch[0].run == dpc_pkg::DPC_IDLE)
      else $error("one-time capture stayed armed");
   a_cont_stays: assert property (
      cap[1] && st_r.ch[1].run == dpc_pkg::DPC_CONT && !wr_ss[1]
      |=> st_r.ch[1].run == dpc_pkg::DPC_CONT)
      else $error("continuous capture disarmed");
   a_status_bits: assert property (
      par_req.rd && par_req.addr == 16'h0A02
      |=> par_rsp.ack && par_rsp.rdata[1:0]
          == {$past(st_r.ch[1].flag), $past(st_r.ch[0].flag)})
      else $error("status word does not show the flags");
   a_pos_stored: assert property (cap[0] |=>
      st_r.ch[0].pos == $past(motor_pos) && st_r.ch[0].flag)
      else $error("captured position not stored");
   a_redefine_shift: assert property (
      pos_redefine && !cap[1]
      |=> st_r.ch[1].pos == $past(st_r.ch[1].pos)
          + $past(pos_redefine_delta))
      else $error("stored position not moved with reference");
   a_count_step: assert property (
      cap[1] && !start[1]
      |=> st_r.ch[1].count == $past(st_r.ch[1].count) + 16'h0001)
      else $error("event counter did not step");
   a_start_clears: assert property (
      start[0] && !cap[0] |=> st_r.ch[0].count == 16'h0000
      && !st_r.ch[0].flag && st_r.ch[0].run != dpc_pkg::DPC_IDLE)
      else $error("start did not clear counter and flag");

   c_once_capture: cover property (
      st_r.ch[0].run == dpc_pkg::DPC_ONCE && cap[0]);
   c_cont_twice: cover property (
      st_r.ch[1].run == dpc_pkg::DPC_CONT && cap[1] ##[1:200] cap[1]);
   c_start_and_edge: cover property (start[0] && cap[0]);
   c_redefine_held: cover property (pos_redefine && st_r.ch[1].flag);

endmodule

//--- dv/dpc_pin_model.sv
// far side of the unit: two capture pins, changed only at clock edges
module dpc_pin_model (
   // clock of the drive, used to place pin changes
   input  wire logic ref_clk,
   // the two capture pins
   output logic      pin_one,
   output logic      pin_two
);
   timeunit 1ns;
   timeprecision 1ps;

   // pins start low so reset leaves no stray edge in the filter
   initial begin
      pin_one = 1'b0;
      pin_two = 1'b0;
   end

   // move one pin, then hold it well past the two-cycle minimum
   task automatic drive(input int ch, input logic lvl);
      @(posedge ref_clk);
      if (ch == 1) begin
         pin_one <= lvl;
      end else begin
         pin_two <= lvl;
      end
      repeat (4) @(posedge ref_clk);
   endtask
endmodule

//--- dv/dpc_capture_bench.sv
`include "dpc_regs.svh"

module dpc_capture_bench;
   timeunit 1ns;
   timeprecision 1ps;

   logic                  ref_clk;            // 200 MHz clock
   logic                  reset;              // synchronous, active high
   logic                  pin_one;            // capture pin, channel one
   logic                  pin_two;            // capture pin, channel two
   logic signed [31:0]    motor_pos;          // position in user units
   logic                  pos_redefine;       // reference redefined pulse
   logic signed [31:0]    pos_redefine_delta; // shift of the reference
   dpc_pkg::dpc_par_req_t par_req;            // parameter request
   dpc_pkg::dpc_par_rsp_t par_rsp;            // parameter answer
   int                    failures;           // mismatches seen
   int                    checked;            // comparisons made
   logic [31:0]           rd_val;             // last read answer

   dpc_capture dpc_capture_inst (
      .ref_clk            (ref_clk),
      .reset              (reset),
      .local_input_one    (pin_one),
      .local_input_two    (pin_two),
      .motor_pos          (motor_pos),
      .pos_redefine       (pos_redefine),
      .pos_redefine_delta (pos_redefine_delta),
      .par_req            (par_req),
      .par_rsp            (par_rsp)
   );

   dpc_pin_model dpc_pin_model_inst (
      .ref_clk (ref_clk),
      .pin_one (pin_one),
      .pin_two (pin_two)
   );

   // free-running clock, 5 ns period
   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end

   // verdict, the one place the run ends
   task automatic stop_test;
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // compare one word of read data
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   // write: one-cycle strobe, no answer comes back
   task automatic wr_par(input logic [15:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      par_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge ref_clk);
      par_req.wr <= 1'b0;
   endtask

   // read: one-cycle strobe, ack looked for under a bound
   task automatic rd_chk(input logic [15:0] a, input logic [31:0] exp);
      bit got;
      got = 1'b0;
      @(posedge ref_clk);
      par_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0000_0000};
      @(posedge ref_clk);
      par_req.rd <= 1'b0;
      for (int i = 0; i < 4 && !got; i++) begin
         #1;
         if (par_rsp.ack === 1'b1) begin
            got = 1'b1;
            rd_val = par_rsp.rdata;
         end else begin
            @(posedge ref_clk);
         end
      end
      if (!got) begin
         rd_val = 32'hDEAD_DEAD;
      end
      check(rd_val, exp);
   endtask

   // pin change plus time for filter and capture to land
   task automatic edge_on(input int ch, input logic lvl);
      dpc_pin_model_inst.drive(ch, lvl);
      repeat (2) @(posedge ref_clk);
   endtask

   // new motor position, placed at a clock edge
   task automatic set_pos(input logic [31:0] v);
      @(posedge ref_clk);
      motor_pos <= v;
   endtask

   // reset values, unmapped read, read-only write ignored
   task automatic t_reset;
      rd_chk(`DPC_OFS_EDGE1, 32'h0000_0000);
      rd_chk(`DPC_OFS_EDGE2, 32'h0000_0000);
      rd_chk(`DPC_OFS_START1, 32'h0000_0000);
      rd_chk(`DPC_OFS_STATUS, 32'h0000_0000);
      rd_chk(16'h0A20, 32'h0000_0000);
      wr_par(`DPC_OFS_POS1, 32'h0000_0005);
      rd_chk(`DPC_OFS_POS1, 32'h0000_0000);
   endtask

   // one-time rising capture on channel one, later edge ignored
   task automatic t_once;
      set_pos(32'h1234_5678);
      wr_par(`DPC_OFS_EDGE1, 32'h0000_0001);
      wr_par(`DPC_OFS_START1, `DPC_CMD_ONCE);
      edge_on(1, 1'b1);
      set_pos(32'h0000_0777);
      rd_chk(`DPC_OFS_POS1, 32'h1234_5678);
      rd_chk(`DPC_OFS_COUNT1, 32'h0000_0001);
      rd_chk(`DPC_OFS_STATUS, 32'h0000_0001);
      edge_on(1, 1'b0);
      edge_on(1, 1'b1);
      rd_chk(`DPC_OFS_POS1, 32'h1234_5678);
      rd_chk(`DPC_OFS_COUNT2, 32'h0000_0000);
   endtask

   // continuous falling capture on channel two, rising edges ignored
   task automatic t_cont;
      wr_par(`DPC_OFS_EDGE2, 32'h0000_0000);
      wr_par(`DPC_OFS_START2, `DPC_CMD_CONT);
      edge_on(2, 1'b1);
      rd_chk(`DPC_OFS_COUNT2, 32'h0000_0000);
      set_pos(32'h0000_0100);
      edge_on(2, 1'b0);
      set_pos(32'hFFFF_FF00);
      edge_on(2, 1'b1);
      edge_on(2, 1'b0);
      rd_chk(`DPC_OFS_POS2, 32'hFFFF_FF00);
      rd_chk(`DPC_OFS_COUNT2, 32'h0000_0002);
      rd_chk(`DPC_OFS_STATUS, 32'h0000_0003);
   endtask

   // reference shift moves both held positions
   task automatic t_redefine;
      @(posedge ref_clk);
      pos_redefine <= 1'b1;
      pos_redefine_delta <= 32'h0000_0200;
      @(posedge ref_clk);
      pos_redefine <= 1'b0;
      rd_chk(`DPC_OFS_POS1, 32'h1234_5878);
      rd_chk(`DPC_OFS_POS2, 32'h0000_0100);
   endtask

   // restart clears, cancel stops, edge change acts at once
   task automatic t_restart;
      wr_par(`DPC_OFS_START2, `DPC_CMD_CONT);
      rd_chk(`DPC_OFS_COUNT2, 32'h0000_0000);
      rd_chk(`DPC_OFS_STATUS, 32'h0000_0001);
      wr_par(`DPC_OFS_START2, `DPC_CMD_STOP);
      // pin two rests low here: raise it first so a real falling edge comes
      edge_on(2, 1'b1);
      edge_on(2, 1'b0);
      rd_chk(`DPC_OFS_COUNT2, 32'h0000_0000);
      wr_par(`DPC_OFS_START1, `DPC_CMD_ONCE);
      wr_par(`DPC_OFS_EDGE1, 32'h0000_0000);
      edge_on(1, 1'b0);
      rd_chk(`DPC_OFS_COUNT1, 32'h0000_0001);
      // an undefined code must disarm a running channel, value kept
      wr_par(`DPC_OFS_START1, `DPC_CMD_CONT);
      wr_par(`DPC_OFS_START1, 32'h0000_0003);
      rd_chk(`DPC_OFS_START1, 32'h0000_0003);
      edge_on(1, 1'b1);
      edge_on(1, 1'b0);
      rd_chk(`DPC_OFS_COUNT1, 32'h0000_0000);
   endtask

   // main sequence
   initial begin
      failures = 0;
      checked = 0;
      reset = 1'b1;
      par_req = '0;
      motor_pos = '0;
      pos_redefine = 1'b0;
      pos_redefine_delta = '0;
      repeat (3) @(posedge ref_clk);
      reset <= 1'b0;
      t_reset();
      t_once();
      t_cont();
      t_redefine();
      t_restart();
      stop_test();
   end

   // watchdog: 4000 cycles, many times what the whole run needs
   initial begin
      #20000;
      failures++;
      stop_test();
   end
endmodule
